// ### boundary_scan_test_access_port_bench.sv
/* Bench for jtb_tap with the tester model. Assumes nothing else. */
`default_nettype none
module boundary_scan_test_access_port_bench;
    import jtb_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic tck, tms, tdi, tdo, tdo_oe, tap_rst, bit_vld, bit_v;
    logic [JTB_BS_LEN-1:0] sv, d;
    logic [JTB_N_OUT-1:0] pin_out, pin_oe;
    logic exp_q[$];
    int seed = 32'hB64ACB4D;
    int error_cnt = 0;
    int tests_run = 0;
    wire logic tdo_w = tdo_oe ? tdo : 1'bz;
    always #2.5 clk = ~clk;
    jtb_tap i_jtb_tap (.i_clk(clk), .i_sys_rst(rst), .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo),
        .o_tdo_oe(tdo_oe), .i_sys_out(sv[JTB_N_OUT-1:0]), .i_sys_oe(sv[2*JTB_N_OUT-1:JTB_N_OUT]),
        .i_pin_in(sv[JTB_BS_LEN-1:2*JTB_N_OUT]), .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_tap_reset(tap_rst));
    jtb_tester i_jtb_tester (.i_clk(clk), .i_tdo(tdo_w), .o_tck(tck), .o_tms(tms), .o_tdi(tdi),
        .o_bit_vld(bit_vld), .o_bit(bit_v));
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    function automatic logic [JTB_BS_LEN-1:0] rnd();
        logic [351:0] v;
        for (int i = 0; i < 11; i++)
            v = {v[319:0], $random(seed)};
        return v[JTB_BS_LEN-1:0];
    endfunction
    task automatic scan(input logic ir, input int n, input logic [JTB_BS_LEN-1:0] din, input logic [JTB_BS_LEN-1:0] ex);
        // Idle first: leaves Test-Logic-Reset, stays put in Run-Test/Idle
        i_jtb_tester.step(1'b0, 1'b0, 1'b0);
        i_jtb_tester.step(1'b1, 1'b0, 1'b0);
        if (ir) i_jtb_tester.step(1'b1, 1'b0, 1'b0);
        i_jtb_tester.step(1'b0, 1'b0, 1'b0);
        i_jtb_tester.step(1'b0, 1'b0, 1'b0);
        for (int i = 0; i < n; i++) begin
            exp_q.push_back(ex[i]);
            i_jtb_tester.step(i == n - 1, din[i], 1'b1);
        end
        i_jtb_tester.step(1'b1, 1'b0, 1'b0);
        i_jtb_tester.step(1'b0, 1'b0, 1'b0);
    endtask
    task automatic load(input logic [JTB_IR_W-1:0] op);
        scan(1'b1, JTB_IR_W, JTB_BS_LEN'(op), JTB_BS_LEN'(JTB_IR_CAPTURE));
    endtask
    task automatic check(input logic [2*JTB_N_OUT:0] e, input string name);
        repeat (4) @(posedge clk);
        tests_run++;
        if ({tap_rst, pin_oe, pin_out} !== e) begin
            error_cnt++;
            $display("ERROR %0t pin drive wrong in %s", $time, name);
        end
        $display("test %s done", name);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d left %0d", tests_run, error_cnt, exp_q.size());
        if (error_cnt == 0 && exp_q.size() == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Serial output scoreboard
    always @(posedge clk) begin
        if (bit_vld === 1'b1) begin
            tests_run++;
            if (exp_q.size() == 0 || bit_v !== exp_q[0]) begin
                error_cnt++;
                $display("ERROR %0t serial output bit wrong", $time);
            end
            if (exp_q.size() != 0) void'(exp_q.pop_front());
        end
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        sv <= rnd();
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        check({1'b1, sv[2*JTB_N_OUT-1:0]}, "reset");
        scan(1'b0, JTB_ID_W, rnd(), JTB_BS_LEN'(JTB_IDCODE_DEF));
        for (int k = 0; k < 2; k++) begin
            load(k ? 4'h5 : JTB_OP_BYPASS);
            d = rnd();
            scan(1'b0, 9, d, JTB_BS_LEN'({d[7:0], JTB_BYPASS_CAPTURE}));
        end
        load(JTB_OP_SAMPLE);
        d = rnd();
        scan(1'b0, JTB_BS_LEN, d, sv);
        check({1'b0, sv[2*JTB_N_OUT-1:0]}, "sample");
        load(JTB_OP_EXTEST);
        check({1'b0, d[2*JTB_N_OUT-1:0]}, "extest");
        load(JTB_OP_CLAMP);
        check({1'b0, d[2*JTB_N_OUT-1:0]}, "clamp");
        sv <= rnd();
        load(JTB_OP_HIGHZ);
        check({1'b0, {JTB_N_OUT{1'b0}}, sv[JTB_N_OUT-1:0]}, "highz");
        for (int k = 0; k < 5; k++)
            i_jtb_tester.step(1'b1, 1'b0, 1'b0);
        check({1'b1, sv[2*JTB_N_OUT-1:0]}, "tlr");
        scan(1'b0, JTB_ID_W, rnd(), JTB_BS_LEN'(JTB_IDCODE_DEF));
        stop_test();
    end
endmodule // boundary_scan_test_access_port_bench
`default_nettype wire

// ### jtb_pkg.sv
/*
 * Constants for the boundary-scan test access port: controller states,
 * instruction codes, register lengths and the boundary cell layout.
 * Assumes nothing of its surroundings.
 */
`default_nettype none
package jtb_pkg;
    // ****************************************************************
    // Controller states, one-hot
    // ****************************************************************
    typedef enum logic [15:0] {
        JTB_TLR  = 16'h0001,
        JTB_RTI  = 16'h0002,
        JTB_SDRS = 16'h0004,
        JTB_CDR  = 16'h0008,
        JTB_SDR  = 16'h0010,
        JTB_E1DR = 16'h0020,
        JTB_PDR  = 16'h0040,
        JTB_E2DR = 16'h0080,
        JTB_UDR  = 16'h0100,
        JTB_SIRS = 16'h0200,
        JTB_CIR  = 16'h0400,
        JTB_SIR  = 16'h0800,
        JTB_E1IR = 16'h1000,
        JTB_PIR  = 16'h2000,
        JTB_E2IR = 16'h4000,
        JTB_UIR  = 16'h8000
    } jtb_state_t;

    // ****************************************************************
    // Instruction register
    // ****************************************************************
    localparam int JTB_IR_W = 4;
    localparam logic [JTB_IR_W-1:0] JTB_OP_EXTEST = 4'h0;
    localparam logic [JTB_IR_W-1:0] JTB_OP_IDCODE = 4'h1;
    localparam logic [JTB_IR_W-1:0] JTB_OP_SAMPLE = 4'h2;
    localparam logic [JTB_IR_W-1:0] JTB_OP_HIGHZ = 4'h9;
    localparam logic [JTB_IR_W-1:0] JTB_OP_CLAMP = 4'hC;
    localparam logic [JTB_IR_W-1:0] JTB_OP_BYPASS = 4'hF;
    localparam logic [JTB_IR_W-1:0] JTB_IR_CAPTURE = 4'h1;

    // ****************************************************************
    // Data registers and boundary layout
    // ****************************************************************
    localparam int JTB_ID_W = 32;
    localparam logic [JTB_ID_W-1:0] JTB_IDCODE_DEF = 32'h0A5A_5001; // Arbitrary value
    localparam logic JTB_BYPASS_CAPTURE = 1'h0;
    localparam int JTB_N_OUT = 100;
    localparam int JTB_N_IN = 126;
    localparam int JTB_BS_LEN = 2 * JTB_N_OUT + JTB_N_IN;
endpackage
`default_nettype wire

// ### jtb_tap.sv
/*
 * Boundary-scan test access port: controller, instruction register,
 * bypass, identification and boundary registers, pin drive muxing.
 * Assumes the tester's clock, mode and data lines are asynchronous to
 * i_clk, and that i_clk runs well over twice the tester clock rate.
 */
// Notes on behaviour
// - Sixteen-state controller sequences capture, shift, update
// - Instruction selects which data register is shifted
// - Bypass register is one single stage
// - Boundary register has 326 serial cells
// - 32-bit identification register shifts out serially
// - All pin cells form one chain
// - Test logic reset by i_sys_rst, otherwise independent of the system logic
// - Sample captures live pins without disturbing them
// - Extest drives pins from cells, captures inputs
// - Highz instruction turns all output drivers off
// - Clamp holds outputs at levels from cells
`default_nettype none
module jtb_tap
    import jtb_pkg::*;
#(
    parameter int N_OUT = jtb_pkg::JTB_N_OUT,
    parameter int N_IN = jtb_pkg::JTB_N_IN,
    parameter logic [jtb_pkg::JTB_ID_W-1:0] IDCODE = jtb_pkg::JTB_IDCODE_DEF
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    output logic o_tdo,
    output logic o_tdo_oe,
    input wire logic [N_OUT-1:0] i_sys_out,
    input wire logic [N_OUT-1:0] i_sys_oe,
    input wire logic [N_IN-1:0] i_pin_in,
    output logic [N_OUT-1:0] o_pin_out,
    output logic [N_OUT-1:0] o_pin_oe,
    output logic o_tap_reset
);
    import jtb_pkg::*;

    localparam int BS_LEN = 2 * N_OUT + N_IN;
    localparam int SYNC_W = 3 + N_IN;

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    logic tck_d_r;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
            tck_d_r <= 1'h0;
        end else begin
            sync1_r <= {i_pin_in, i_tdi, i_tms, i_tck};
            sync2_r <= sync1_r;
            tck_d_r <= sync2_r[0];
        end
    end

    wire tck_s = sync2_r[0];
    wire tms_s = sync2_r[1];
    wire tdi_s = sync2_r[2];
    wire [N_IN-1:0] pin_in_s = sync2_r[SYNC_W-1:3];
    wire tck_rise = tck_s & ~tck_d_r;
    wire tck_fall = ~tck_s & tck_d_r;

    // ****************************************************************
    // Controller
    // ****************************************************************
    jtb_state_t state_r;
    jtb_state_t state_nxt;

    always_comb begin
        case (state_r)
            JTB_TLR: state_nxt = tms_s ? JTB_TLR : JTB_RTI;
            JTB_RTI: state_nxt = tms_s ? JTB_SDRS : JTB_RTI;
            JTB_SDRS: state_nxt = tms_s ? JTB_SIRS : JTB_CDR;
            JTB_CDR: state_nxt = tms_s ? JTB_E1DR : JTB_SDR;
            JTB_SDR: state_nxt = tms_s ? JTB_E1DR : JTB_SDR;
            JTB_E1DR: state_nxt = tms_s ? JTB_UDR : JTB_PDR;
            JTB_PDR: state_nxt = tms_s ? JTB_E2DR : JTB_PDR;
            JTB_E2DR: state_nxt = tms_s ? JTB_UDR : JTB_SDR;
            JTB_UDR: state_nxt = tms_s ? JTB_SDRS : JTB_RTI;
            JTB_SIRS: state_nxt = tms_s ? JTB_TLR : JTB_CIR;
            JTB_CIR: state_nxt = tms_s ? JTB_E1IR : JTB_SIR;
            JTB_SIR: state_nxt = tms_s ? JTB_E1IR : JTB_SIR;
            JTB_E1IR: state_nxt = tms_s ? JTB_UIR : JTB_PIR;
            JTB_PIR: state_nxt = tms_s ? JTB_E2IR : JTB_PIR;
            JTB_E2IR: state_nxt = tms_s ? JTB_UIR : JTB_SIR;
            JTB_UIR: state_nxt = tms_s ? JTB_SDRS : JTB_RTI;
            default: state_nxt = JTB_TLR;
        endcase
    end

    // Reset by i_sys_rst; otherwise moves only on test clock rising edges
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_r <= JTB_TLR;
        end else if (tck_rise) begin
            state_r <= state_nxt;
        end
    end

    // ****************************************************************
    // Instruction decode and register select
    // ****************************************************************
    logic [JTB_IR_W-1:0] ir_sh_r;
    logic [JTB_IR_W-1:0] ir_r;

    wire op_extest = (ir_r == JTB_OP_EXTEST);
    wire op_sample = (ir_r == JTB_OP_SAMPLE);
    wire op_idcode = (ir_r == JTB_OP_IDCODE);
    wire op_highz = (ir_r == JTB_OP_HIGHZ);
    wire op_clamp = (ir_r == JTB_OP_CLAMP);
    wire sel_bs = op_extest | op_sample;
    wire sel_id = op_idcode;
    wire sel_byp = ~sel_bs & ~sel_id;

    wire cap_ir = tck_rise & (state_r == JTB_CIR);
    wire sh_ir = tck_rise & (state_r == JTB_SIR);
    wire upd_ir = tck_fall & (state_r == JTB_UIR);
    wire cap_dr = tck_rise & (state_r == JTB_CDR);
    wire sh_dr = tck_rise & (state_r == JTB_SDR);
    wire upd_dr = tck_fall & (state_r == JTB_UDR);
    wire in_tlr = (state_r == JTB_TLR);

    // ****************************************************************
    // Instruction register
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ir_sh_r <= JTB_IR_CAPTURE;
            ir_r <= JTB_OP_IDCODE;
        end else begin
            if (cap_ir) begin
                ir_sh_r <= JTB_IR_CAPTURE;
            end else if (sh_ir) begin
                ir_sh_r <= {tdi_s, ir_sh_r[JTB_IR_W-1:1]};
            end
            if (in_tlr) begin
                ir_r <= JTB_OP_IDCODE;
            end else if (upd_ir) begin
                ir_r <= ir_sh_r;
            end
        end
    end

    // ****************************************************************
    // Data registers
    // ****************************************************************
    logic byp_r;
    logic [JTB_ID_W-1:0] id_r;
    logic [BS_LEN-1:0] bs_r;
    logic [BS_LEN-1:0] bsu_r;

    // Output data cells low, then enable cells, then input cells
    wire [BS_LEN-1:0] bs_cap = {pin_in_s, o_pin_oe, o_pin_out};

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            byp_r <= JTB_BYPASS_CAPTURE;
            id_r <= IDCODE;
        end else begin
            if (cap_dr & sel_byp) begin
                byp_r <= JTB_BYPASS_CAPTURE;
            end else if (sh_dr & sel_byp) begin
                byp_r <= tdi_s;
            end
            if (cap_dr & sel_id) begin
                id_r <= IDCODE;
            end else if (sh_dr & sel_id) begin
                id_r <= {tdi_s, id_r[JTB_ID_W-1:1]};
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            bs_r <= '0;
            bsu_r <= '0;
        end else begin
            if (cap_dr & sel_bs) begin
                bs_r <= bs_cap;
            end else if (sh_dr & sel_bs) begin
                bs_r <= {tdi_s, bs_r[BS_LEN-1:1]};
            end
            if (upd_dr & sel_bs) begin
                bsu_r <= bs_r;
            end
        end
    end

    // ****************************************************************
    // Serial output, changed on the falling test clock
    // ****************************************************************
    wire in_shift = (state_r == JTB_SDR) | (state_r == JTB_SIR);
    wire dr_bit = sel_bs ? bs_r[0] : (sel_id ? id_r[0] : byp_r);
    wire tdo_nxt = (state_r == JTB_SIR) ? ir_sh_r[0] : dr_bit;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_tdo <= 1'h0;
            o_tdo_oe <= 1'h0;
        end else if (tck_fall) begin
            o_tdo <= tdo_nxt;
            o_tdo_oe <= in_shift;
        end
    end

    // ****************************************************************
    // Pin drive
    // ****************************************************************
    wire pins_from_cells = op_extest | op_clamp;
    wire [N_OUT-1:0] pin_out_nxt = pins_from_cells ? bsu_r[N_OUT-1:0] : i_sys_out;
    wire [N_OUT-1:0] pin_oe_cell = pins_from_cells ? bsu_r[2*N_OUT-1:N_OUT] : i_sys_oe;
    wire [N_OUT-1:0] pin_oe_nxt = op_highz ? '0 : pin_oe_cell;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_pin_out <= '0;
            o_pin_oe <= '0;
            o_tap_reset <= 1'h1;
        end else begin
            o_pin_out <= pin_out_nxt;
            o_pin_oe <= pin_oe_nxt;
            o_tap_reset <= in_tlr;
        end
    end
endmodule // jtb_tap
`default_nettype wire

// ### jtb_tap_sva.sv
/* Port checker for jtb_tap, bound into it. Assumes tck phases of six i_clk or more. */
`default_nettype none
module jtb_tap_sva #(
    parameter int N_OUT = jtb_pkg::JTB_N_OUT,
    parameter int N_IN = jtb_pkg::JTB_N_IN
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    input wire logic o_tdo,
    input wire logic o_tdo_oe,
    input wire logic [N_OUT-1:0] i_sys_out,
    input wire logic [N_OUT-1:0] i_sys_oe,
    input wire logic [N_IN-1:0] i_pin_in,
    input wire logic [N_OUT-1:0] o_pin_out,
    input wire logic [N_OUT-1:0] o_pin_oe,
    input wire logic o_tap_reset
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // ****************************************************************
    // Link timing and reset behaviour
    // ****************************************************************
    sequence s_tck_high; i_tck [*6]; endsequence
    sequence s_in_tlr; o_tap_reset [*3] ##0 !$past(i_sys_rst); endsequence
    property p_rst_out; disable iff (1'b0) i_sys_rst |=> o_tap_reset && !o_tdo_oe && !o_tdo; endproperty
    a_rst_out: assert property (p_rst_out) else $error("reset state wrong");
    property p_rst_pins; disable iff (1'b0) i_sys_rst |=> o_pin_oe == '0 && o_pin_out == '0; endproperty
    a_rst_pins: assert property (p_rst_pins) else $error("pins not quiet in reset");
    property p_tlr_follow; s_in_tlr |-> o_pin_out == $past(i_sys_out) && o_pin_oe == $past(i_sys_oe); endproperty
    a_tlr_follow: assert property (p_tlr_follow) else $error("pins not following system");
    property p_tdo_fall; $changed(o_tdo) |-> !$past(i_tck, 2); endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("tdo changed off the fall");
    property p_oe_fall; $changed(o_tdo_oe) |-> !$past(i_tck, 2); endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("tdo enable changed off the fall");
    property p_tdo_hold; s_tck_high |-> $stable(o_tdo); endproperty
    a_tdo_hold: assert property (p_tdo_hold) else $error("tdo moved while tck high");
    property p_oe_hold; s_tck_high |-> $stable(o_tdo_oe); endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("tdo enable moved while tck high");
    property p_oe_shift; o_tdo_oe |-> !o_tap_reset; endproperty
    a_oe_shift: assert property (p_oe_shift) else $error("tdo driven in reset state");
endmodule // jtb_tap_sva
bind jtb_tap jtb_tap_sva #(.N_OUT(N_OUT), .N_IN(N_IN)) i_jtb_tap_sva (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_tck(i_tck), .i_tms(i_tms), .i_tdi(i_tdi),
    .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .i_sys_out(i_sys_out), .i_sys_oe(i_sys_oe), .i_pin_in(i_pin_in),
    .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_tap_reset(o_tap_reset)
);
`default_nettype wire

// ### jtb_tester.sv
/* Board tester model driving the test link. Assumes a 5 ns i_clk paces it. */
`default_nettype none
module jtb_tester (
    input wire logic i_clk,
    input wire logic i_tdo,
    output var logic o_tck = 1'b0,
    output var logic o_tms = 1'b1,
    output var logic o_tdi = 1'b0,
    output var logic o_bit_vld = 1'b0,
    output var logic o_bit = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************************************
    // One 160 ns test clock period; clock stands low between calls
    // ****************************************************************
    task automatic step(input logic tms, input logic tdi, input logic chk);
        @(posedge i_clk);
        o_tms <= tms;
        o_tdi <= tdi;
        repeat (15) @(posedge i_clk);
        o_bit <= i_tdo;
        o_bit_vld <= chk;
        o_tck <= 1'b1;
        @(posedge i_clk);
        o_bit_vld <= 1'b0;
        repeat (15) @(posedge i_clk);
        o_tck <= 1'b0;
        o_tdi <= ~tdi;
    endtask
endmodule // jtb_tester
`default_nettype wire
